//--- adcms_pkg.sv
// Constants for the converter mode sequencer: register map, fields,
// reset values, modes, states and conversion lengths.
// Assumes a 32-bit APB register bus with byte addresses.
`default_nettype none

package adcms_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADCMS_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  ADCMS_STAT_OFS   = 8'h04;
  localparam logic [7:0]  ADCMS_MASK_OFS   = 8'h08;
  localparam logic [7:0]  ADCMS_RES_FIRST  = 8'h10;
  localparam logic [7:0]  ADCMS_RES_LAST   = 8'h2C;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int          ADCMS_CTRL_W     = 13;
  localparam int          ADCMS_MODE_LSB   = 0;
  localparam int          ADCMS_CHAN_LSB   = 3;
  localparam int          ADCMS_SWEEP_LSB  = 6;
  localparam int          ADCMS_START_BIT  = 8;
  localparam int          ADCMS_EXT_BIT    = 9;
  localparam int          ADCMS_TEN_BIT    = 10;
  localparam int          ADCMS_SH_BIT     = 11;
  localparam int          ADCMS_DIV4_BIT   = 12;
  localparam logic [12:0] ADCMS_CTRL_RESET = 13'h0000;

  // ----------------------------------------------------------------------
  // Status and mask fields
  // ----------------------------------------------------------------------
  localparam int          ADCMS_DONE_BIT   = 0;
  localparam int          ADCMS_BUSY_BIT   = 8;
  localparam logic        ADCMS_MASK_RESET = 1'h0;

  // ----------------------------------------------------------------------
  // Conversion lengths in converter clock ticks, and the divide-by-4 last count
  // ----------------------------------------------------------------------
  localparam logic [5:0]  ADCMS_CYC_8B     = 6'h31;
  localparam logic [5:0]  ADCMS_CYC_10B    = 6'h3B;
  localparam logic [5:0]  ADCMS_CYC_SH_8B  = 6'h1C;
  localparam logic [5:0]  ADCMS_CYC_SH_10B = 6'h21;
  localparam logic [1:0]  ADCMS_DIV4_LAST  = 2'h3;

  // ----------------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCMS_ONESHOT = 3'h0,
    ADCMS_REPEAT  = 3'h1,
    ADCMS_SWEEP   = 3'h2,
    ADCMS_RSWEEP0 = 3'h3,
    ADCMS_RSWEEP1 = 3'h4
  } adcms_mode_t;

  typedef enum logic [2:0] {
    ADCMS_IDLE    = 3'b001,
    ADCMS_WTRIG   = 3'b010,
    ADCMS_CONVERT = 3'b100
  } adcms_state_t;

endpackage

`default_nettype wire

//--- adcms_top.sv
// Mode sequencer for an eight-input successive approximation converter.
// Assumes an APB master, an analog core whose result is valid at the end
// of each conversion, and a trigger input synchronous to pclk.
//
// Implementation choices: the APB register port and the address map.
`default_nettype none

module adcms_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog core
  input  wire logic [9:0]  analog_result,
  output logic             conv_active,
  output logic [2:0]       conv_channel,
  output logic             conv_done,
  // Trigger and interrupt
  input  wire logic        external_conversion_trigger,
  output logic             irq
);
  import adcms_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------------
  logic [12:0]  ctrl;
  logic         status_done;
  logic         mask_done;
  logic [9:0]   results [8];
  adcms_state_t state;
  adcms_state_t next_state;

  wire       bus_acc  = psel & penable;
  wire       bus_wr   = bus_acc & pwrite;
  wire       bus_rd   = bus_acc & ~pwrite;
  wire       sel_ctrl = (paddr == ADCMS_CTRL_OFS);
  wire       sel_stat = (paddr == ADCMS_STAT_OFS);
  wire       sel_mask = (paddr == ADCMS_MASK_OFS);
  wire       sel_res  = (paddr >= ADCMS_RES_FIRST) &&
                        (paddr <= ADCMS_RES_LAST) && (paddr[1:0] == 2'h0);
  wire [7:0] res_off  = 8'(paddr - ADCMS_RES_FIRST);
  wire [2:0] res_idx  = res_off[4:2];
  wire       mapped   = sel_ctrl | sel_stat | sel_mask | sel_res;
  wire       wr_ctrl  = bus_wr & sel_ctrl;
  wire       rd_stat  = bus_rd & sel_stat;

  assign pready  = 1'b1;
  assign pslverr = bus_acc & ~mapped;

  wire [31:0] rd_ctrl_w = {19'h0, ctrl};
  wire [31:0] rd_stat_w = {23'h0, conv_active, 7'h0, status_done};
  wire [31:0] rd_mask_w = {31'h0, mask_done};
  wire [31:0] rd_res_w  = {22'h0, results[res_idx]};

  assign prdata = sel_ctrl ? rd_ctrl_w :
                  sel_stat ? rd_stat_w :
                  sel_mask ? rd_mask_w :
                  sel_res  ? rd_res_w  : 32'h0;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  wire [2:0] mode_raw   = ctrl[ADCMS_MODE_LSB +: 3];
  wire [2:0] chan_sel   = ctrl[ADCMS_CHAN_LSB +: 3];
  wire [1:0] sweep_sel  = ctrl[ADCMS_SWEEP_LSB +: 2];
  wire       start_flag = ctrl[ADCMS_START_BIT];
  wire       ext_trig   = ctrl[ADCMS_EXT_BIT];
  wire       ten_bit    = ctrl[ADCMS_TEN_BIT];
  wire       samp_hold  = ctrl[ADCMS_SH_BIT];
  wire       div4       = ctrl[ADCMS_DIV4_BIT];

  // Undefined mode codes behave as one-shot so the flag clears unless ext_trig is set.
  wire m_repeat  = (mode_raw == ADCMS_REPEAT);
  wire m_sweep   = (mode_raw == ADCMS_SWEEP);
  wire m_rsweep0 = (mode_raw == ADCMS_RSWEEP0);
  wire m_rsweep1 = (mode_raw == ADCMS_RSWEEP1);
  wire m_oneshot = ~(m_repeat | m_sweep | m_rsweep0 | m_rsweep1);

  wire [2:0] sweep_last = {sweep_sel, 1'b1};
  wire [2:0] grp_last   = {1'b0, sweep_sel};
  wire [2:0] grp_size   = 3'({1'b0, sweep_sel} + 3'h1);

  // ----------------------------------------------------------------------
  // Converter clock divider and conversion length
  // ----------------------------------------------------------------------
  logic [1:0] div_cnt;
  logic [5:0] conv_cnt;
  logic       trig_q;
  logic       in_grp;
  logic [2:0] other_ch;

  wire ad_tick = div4 ? (div_cnt == ADCMS_DIV4_LAST) : div_cnt[0];

  wire [5:0] conv_len = samp_hold ?
                        (ten_bit ? ADCMS_CYC_SH_10B : ADCMS_CYC_SH_8B) :
                        (ten_bit ? ADCMS_CYC_10B : ADCMS_CYC_8B);
  wire [5:0] cnt_last = 6'(conv_len - 6'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= 2'(div_cnt + 2'h1);
    end
  end

  // ----------------------------------------------------------------------
  // Sequencing events
  // ----------------------------------------------------------------------
  wire is_idle  = (state == ADCMS_IDLE);
  wire is_conv  = (state == ADCMS_CONVERT);
  wire trig_fall = trig_q & ~external_conversion_trigger;

  wire stop     = ~start_flag | (wr_ctrl & ~pwdata[ADCMS_START_BIT]);
  wire launch   = (is_idle & start_flag & ~ext_trig) |
                  (start_flag & ext_trig & trig_fall);
  wire end_conv = is_conv & ad_tick & (conv_cnt == cnt_last);
  wire op_end   = end_conv & ~stop & ~launch &
                  (m_oneshot | (m_sweep & (conv_channel == sweep_last)));
  wire self_clr = op_end & ~ext_trig;
  wire step     = end_conv & ~stop & ~launch & ~op_end;

  always_comb begin
    next_state = state;
    if (stop) begin
      next_state = ADCMS_IDLE;
    end else if (launch) begin
      next_state = ADCMS_CONVERT;
    end else if (op_end) begin
      next_state = ext_trig ? ADCMS_WTRIG : ADCMS_IDLE;
    end else if (is_idle && ext_trig) begin
      next_state = ADCMS_WTRIG;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= ADCMS_IDLE;
      trig_q <= 1'b1;
    end else begin
      state  <= next_state;
      trig_q <= external_conversion_trigger;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt <= 6'h00;
    end else if (launch || end_conv) begin
      conv_cnt <= 6'h00;
    end else if (is_conv && ad_tick) begin
      conv_cnt <= 6'(conv_cnt + 6'h01);
    end
  end

  // ----------------------------------------------------------------------
  // Channel order
  // ----------------------------------------------------------------------
  logic [2:0] next_ch;
  logic [2:0] next_other;
  logic       next_in_grp;
  logic [2:0] other_inc;

  always_comb begin
    next_ch     = conv_channel;
    next_other  = other_ch;
    next_in_grp = in_grp;
    other_inc   = (other_ch == 3'h7) ? grp_size : 3'(other_ch + 3'h1);
    if (launch) begin
      next_ch     = (m_oneshot | m_repeat) ? chan_sel : 3'h0;
      next_other  = grp_size;
      next_in_grp = 1'b1;
    end else if (step) begin
      if (m_repeat) begin
        next_ch = chan_sel;
      end else if (m_rsweep1) begin
        if (in_grp && conv_channel != grp_last) begin
          next_ch = 3'(conv_channel + 3'h1);
        end else if (in_grp) begin
          next_ch     = other_ch;
          next_in_grp = 1'b0;
        end else begin
          next_ch     = 3'h0;
          next_other  = other_inc;
          next_in_grp = 1'b1;
        end
      end else begin
        next_ch = (conv_channel == sweep_last) ? 3'h0 :
                  3'(conv_channel + 3'h1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_channel <= 3'h0;
      other_ch     <= 3'h1;
      in_grp       <= 1'b1;
    end else begin
      conv_channel <= next_ch;
      other_ch     <= next_other;
      in_grp       <= next_in_grp;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ADCMS_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[ADCMS_CTRL_W-1:0];
    end else if (self_clr) begin
      ctrl[ADCMS_START_BIT] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  // 8-bit precision keeps analog_result[9:2], right aligned
  wire [9:0] store_val = ten_bit ? analog_result :
                                   {2'h0, analog_result[9:2]};

  genvar gi;
  for (gi = 0; gi < 8; gi++) begin : g_res
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        results[gi] <= 10'h000;
      end else if (end_conv && !stop && conv_channel == 3'(gi)) begin
        results[gi] <= store_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_done <= 1'b0;
      mask_done   <= ADCMS_MASK_RESET;
      conv_done   <= 1'b0;
      conv_active <= 1'b0;
    end else begin
      if (op_end) begin
        status_done <= 1'b1;
      end else if (rd_stat) begin
        status_done <= 1'b0;
      end
      if (bus_wr && sel_mask) begin
        mask_done <= pwdata[ADCMS_DONE_BIT];
      end
      conv_done   <= end_conv & ~stop;
      conv_active <= (next_state == ADCMS_CONVERT);
    end
  end

  assign irq = status_done & mask_done;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  stop_on_clear_a: assert property (
    wr_ctrl && !pwdata[ADCMS_START_BIT] |=> is_idle && !conv_active)
    else $error("conversion kept running after start flag cleared");

  flag_self_clear_a: assert property (
    op_end && !ext_trig && !wr_ctrl |=> !start_flag ##1 is_idle)
    else $error("start flag not cleared at end of operation");

  ext_flag_kept_a: assert property (
    op_end && ext_trig && !wr_ctrl |=> start_flag && state == ADCMS_WTRIG)
    else $error("start flag lost with external trigger");

  irq_on_end_a: assert property (
    op_end && mask_done && !(bus_wr && sel_mask) |=> irq)
    else $error("no interrupt after completed operation");

  repeat_no_irq_a: assert property (
    !status_done && end_conv && (m_repeat || m_rsweep0 || m_rsweep1)
    |=> !status_done)
    else $error("interrupt raised in a repeating mode");

  repeat_chan_a: assert property (
    is_conv && !launch && (m_repeat || m_oneshot) |-> conv_channel == chan_sel)
    else $error("wrong input in single input mode");

  sweep_range_a: assert property (
    is_conv && (m_sweep || m_rsweep0) |-> conv_channel <= sweep_last)
    else $error("input outside sweep set");

  sweep_step_a: assert property (
    step && (m_sweep || m_rsweep0) && conv_channel != sweep_last
    |=> conv_channel == $past(conv_channel) + 3'h1)
    else $error("sweep skipped an input");

  emphasis_back_a: assert property (
    step && m_rsweep1 && !in_grp |=> conv_channel == 3'h0 && in_grp)
    else $error("emphasised input not revisited");

  trig_start_a: assert property (
    trig_fall && start_flag && ext_trig && !stop
    |=> is_conv && conv_cnt == 6'h00)
    else $error("trigger edge did not start a conversion");

  conv_len_a: assert property (
    end_conv |-> conv_cnt == (samp_hold ? (ten_bit ? 6'h20 : 6'h1B) :
                                          (ten_bit ? 6'h3A : 6'h30)))
    else $error("conversion length differs from its precision");

  oneshot_cov: cover property (op_end && m_oneshot);
  sweep_cov:   cover property (op_end && m_sweep && sweep_sel == 2'h3);
  rsw1_cov:    cover property (step && m_rsweep1 && conv_channel == 3'h7);
  retrig_cov:  cover property (is_conv && launch && ext_trig);

endmodule // adcms_top

`default_nettype wire

//--- adcms_bench.sv
// Self-checking bench for the converter mode sequencer.
// Assumes adcms_pkg and adcms_top are compiled first; APB driven here.
`default_nettype none

module adcms_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import adcms_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  analog_result;
  logic        conv_active;
  logic [2:0]  conv_channel;
  logic        conv_done;
  logic        trig;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  ch_d;
  logic [2:0]  exp_ch[$];
  int          mismatches;
  int          num_checks;

  adcms_top u_adcms_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_result(analog_result),
    .conv_active(conv_active), .conv_channel(conv_channel),
    .conv_done(conv_done), .external_conversion_trigger(trig), .irq(irq)
  );

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [31:0] cw(int m, int c, int s, int o, bit st,
                                     bit ex);
    cw = 32'h0;
    cw[ADCMS_MODE_LSB +: 3]  = m[2:0];
    cw[ADCMS_CHAN_LSB +: 3]  = c[2:0];
    cw[ADCMS_SWEEP_LSB +: 2] = s[1:0];
    cw[ADCMS_START_BIT]      = st;
    cw[ADCMS_EXT_BIT]        = ex;
    cw[ADCMS_TEN_BIT]        = o[0];
    cw[ADCMS_SH_BIT]         = o[1];
    cw[ADCMS_DIV4_BIT]       = o[2];
  endfunction

  // Channel expected as the k-th conversion of a run in mode m.
  function automatic logic [2:0] nth(int m, int c, int s, int k);
    int g;
    int p;
    g = s + 1;
    p = k % ((8 - g) * (g + 1));
    if (m < 2) nth = c[2:0];
    else if (m < 4) nth = 3'(k % (2 * s + 2));
    else if (p % (g + 1) < g) nth = 3'(p % (g + 1));
    else nth = 3'(g + p / (g + 1));
  endfunction

  task automatic wq(int n);
    int t;
    t = 0;
    while (exp_ch.size() != 0 && t < 300 * n + 100) begin
      @(posedge pclk);
      t++;
    end
    chk(32'(exp_ch.size()), 32'h0);
    exp_ch.delete();
  endtask

  task automatic conv(int m, int c, int s, int o, int n);
    logic [9:0]  ar;
    logic [31:0] w;
    int          k;
    ar = 10'($urandom);
    @(posedge pclk) analog_result <= ar;
    w = o[0] ? {22'h0, ar} : {24'h0, ar[9:2]};
    wr(ADCMS_CTRL_OFS, cw(m, c, s, o, 1'b0, 1'b0));
    for (k = 0; k < n; k++) exp_ch.push_back(nth(m, c, s, k));
    wr(ADCMS_CTRL_OFS, cw(m, c, s, o, 1'b1, 1'b0));
    wq(n);
    if (m == 0 || m == 2) begin
      @(posedge pclk);
      chk(irq, 1'h1);
      apb(1'b0, ADCMS_CTRL_OFS, 32'h0);
      chk(rd[ADCMS_START_BIT], 1'h0);
      apb(1'b0, ADCMS_STAT_OFS, 32'h0);
      chk(rd[8:0], 9'h001);
      @(posedge pclk);
      chk(irq, 1'h0);
    end else begin
      wr(ADCMS_CTRL_OFS, cw(m, c, s, o, 1'b0, 1'b0));
      repeat (2) @(posedge pclk);
      chk(conv_active, 1'h0);
      repeat (300) @(posedge pclk);
      apb(1'b0, ADCMS_STAT_OFS, 32'h0);
      chk(rd[8:0], 9'h000);
      chk(irq, 1'h0);
    end
    for (k = 0; k < 8; k++) begin
      if (m < 2 ? k == c : (m < 4 ? k <= 2 * s + 1 : 1'b1)) begin
        apb(1'b0, ADCMS_RES_FIRST + 8'(4 * k), 32'h0);
        chk(rd, w);
      end
    end
    $display("test mode %0d sel %0d done", m, s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // --------------------------------------------------------------------
  // Clock, monitor and watchdog
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // The channel of each completed conversion is matched against the oldest expected channel.
  always @(posedge pclk) begin
    if (presetn === 1'b1 && conv_done === 1'b1) begin
      if (exp_ch.size() == 0) chk({29'h0, ch_d}, 32'hFFFFFFFF);
      else chk({29'h0, ch_d}, {29'h0, exp_ch.pop_front()});
    end
    ch_d = conv_channel;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(15));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    analog_result = 10'h000;
    trig          = 1'b1;
    presetn       = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADCMS_CTRL_OFS, 32'h0);
    chk(rd[12:0], ADCMS_CTRL_RESET);
    apb(1'b0, ADCMS_MASK_OFS, 32'h0);
    chk(rd[0], ADCMS_MASK_RESET);
    wr(ADCMS_MASK_OFS, 32'h1);
    conv(0, $urandom_range(7, 0), 0, 0, 1);
    conv(0, 5, 0, 5, 1);
    for (int s = 0; s < 4; s++) conv(2, 0, s, 2, 2 * s + 2);
    conv(1, 3, 0, 1, 3);
    for (int s = 0; s < 4; s++) conv(3, 0, s, 3, 2 * s + 4);
    for (int s = 0; s < 4; s++) conv(4, 0, s, 2, (7 - s) * (s + 2) + 2);
    wr(ADCMS_MASK_OFS, 32'h0);
    wr(ADCMS_CTRL_OFS, cw(0, 6, 0, 0, 1'b0, 1'b1));
    wr(ADCMS_CTRL_OFS, cw(0, 6, 0, 0, 1'b1, 1'b1));
    repeat (5) @(posedge pclk);
    chk(conv_active, 1'h0);
    exp_ch.push_back(3'h6);
    trig <= 1'b0;
    repeat (3) @(posedge pclk);
    trig <= 1'b1;
    wq(1);
    @(posedge pclk);
    chk(irq, 1'h0);
    wr(ADCMS_MASK_OFS, 32'h1);
    @(posedge pclk);
    chk(irq, 1'h1);
    apb(1'b0, ADCMS_CTRL_OFS, 32'h0);
    chk(rd[ADCMS_START_BIT], 1'h1);
    apb(1'b0, ADCMS_STAT_OFS, 32'h0);
    @(posedge pclk);
    chk(irq, 1'h0);
    wr(ADCMS_CTRL_OFS, 32'h0);
    $display("test external trigger done");
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    wr(8'h05, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1);
    $display("test unmapped done");
    wrap_up();
  end
endmodule // adcms_bench

`default_nettype wire
